/* File: thd_params.svh */
// constants for the distortion alarm-delay and event-logging stage
// What this block does
// RULE1: alarm rises only after start lasted fixed delay; no inverse curve.
// RULE2: alarm delay in 0.005 s steps, default 10.000 s, for phase voltages.
// RULE3: rising and falling edges of start, alarm, blocked give six events.
// RULE4: per source, store only ON, only OFF, or both events in main buffer.
// RULE5: every event carries the time stamp taken at the status change.
// RULE6: start, alarm and blocked are live outputs for I/O and user logic.
// RULE7: one clearable counter each for start, alarm, blocked activations.
// RULE8: rolling log of last 12 records; when full the oldest is overwritten.
// RULE9: log records written only on ON events of start, alarm, blocked.
// RULE10: record: ms stamp, event, three phase distortions, setting group.
// RULE11: active start releases only below 97 % of the pick-up setting.
// RULE12: blocking at pick-up gives blocked, not start; active start resets.
// RULE13: blocking input sampled at the start of each program cycle.
// RULE14: delay timer clears when start drops early; alarm drops with start.
`ifndef THD_PARAMS_SVH
`define THD_PARAMS_SVH

`define DELAY_STEP_US        5000
`define DELAY_DEFAULT_MS     10000
`define DELAY_DEFAULT_STEPS  ((`DELAY_DEFAULT_MS * 1000) / `DELAY_STEP_US)
`define RESET_RATIO_PCT      97
`define PICKUP_DEFAULT       14'h03e8

`define REG_CTRL      8'h00
`define REG_DELAY     8'h04
`define REG_PICKUP    8'h08
`define REG_STATUS    8'h0c
`define REG_CNT_CLR   8'h10
`define REG_CNT_START 8'h14
`define REG_CNT_ALARM 8'h18
`define REG_CNT_BLK   8'h1c
`define REG_IRQ_STAT  8'h20
`define REG_IRQ_CLR   8'h24
`define REG_IRQ_EN    8'h28
`define REG_LOG_SEL   8'h2c
`define REG_LOG_W0    8'h30
`define REG_LOG_W1    8'h34
`define REG_LOG_W2    8'h38
`define REG_LOG_W3    8'h3c

`define CTRL_EN_BIT      0
`define CTRL_SEL_START   2
`define CTRL_SEL_ALARM   4
`define CTRL_SEL_BLK     6
`define SEL_ON_BIT       0
`define SEL_OFF_BIT      1
`define SEL_RESET        2'h3

`define EVB_START_ON   0
`define EVB_START_OFF  1
`define EVB_ALARM_ON   2
`define EVB_ALARM_OFF  3
`define EVB_BLK_ON     4
`define EVB_BLK_OFF    5

`endif

/* File: thd_pkg.sv */
// types shared by the distortion event logger and its log memory
package thd_pkg;

  typedef logic [15:0] thd_val_t;
  typedef logic [47:0] stamp_t;
  typedef logic [5:0]  ev_vec_t;

  typedef enum logic [1:0] {
    EV_START   = 2'b00,
    EV_ALARM   = 2'b01,
    EV_BLOCKED = 2'b10
  } ev_kind_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01,
    BUS_DONE = 2'b10
  } bus_phase_t;

  typedef struct packed {
    stamp_t              stamp;
    ev_kind_t            kind;
    logic [2:0]          group;
    thd_val_t [2:0]      thd;
  } log_rec_t;

  typedef struct packed {
    logic     valid;
    ev_vec_t  flags;
    stamp_t   stamp;
  } ev_msg_t;

endpackage : thd_pkg

/* File: log_mem.sv */
// ring storage for operation records with a registered read port
`timescale 1ns/1ps
module log_mem #(
  parameter int DEPTH = 12,
  parameter int AW    = 4
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire thd_pkg::log_rec_t wr_data,
  input  wire logic [AW-1:0]     rd_addr,
  output thd_pkg::log_rec_t      rd_data
);

  typedef struct packed {
    thd_pkg::log_rec_t [DEPTH-1:0] mem;
    thd_pkg::log_rec_t             rd;
  } mem_state_t;

  mem_state_t state_ff;
  mem_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (wr_en) begin
      nxt_state.mem[wr_addr] = wr_data;
    end
    nxt_state.rd = state_ff.mem[rd_addr];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data = state_ff.rd;

endmodule : log_mem

/* File: thd_alarm_delay_event_logger.sv */
// alarm delay, event generation, counters and record log for the monitor
`timescale 1ns/1ps
`include "thd_params.svh"
module thd_alarm_delay_event_logger #(
  parameter int DELAY_W   = 19,
  parameter int CNT_W     = 32,
  parameter int LOG_DEPTH = 12
) (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  input  wire logic                    ce,
  input  wire logic                    cycle_tick,
  input  wire logic                    block_in,
  input  wire thd_pkg::thd_val_t [2:0] phase_thd,
  input  wire thd_pkg::stamp_t         ts_ms,
  input  wire logic [2:0]              active_group,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         start_out,
  output logic                         alarm_out,
  output logic                         blocked_out,
  output thd_pkg::ev_msg_t             ev_out,
  output logic                         irq
);

  localparam int PW = $clog2(LOG_DEPTH);
  localparam logic [DELAY_W-1:0] DELAY_RST =
    DELAY_W'(`DELAY_DEFAULT_STEPS);

  typedef struct packed {
    thd_pkg::bus_phase_t       bus;
    logic                      waitreq;
    logic [31:0]               rdata;
    logic                      en;
    logic [1:0]                sel_start;
    logic [1:0]                sel_alarm;
    logic [1:0]                sel_blk;
    logic [DELAY_W-1:0]        delay;
    logic [13:0]               pickup;
    logic                      start;
    logic                      alarm;
    logic                      blocked;
    logic [DELAY_W-1:0]        tmr;
    logic [2:0][CNT_W-1:0]     cnt;
    thd_pkg::ev_vec_t          ist;
    thd_pkg::ev_vec_t          ien;
    logic                      irq;
    thd_pkg::ev_msg_t          ev;
    logic [2:0]                pend;
    thd_pkg::log_rec_t         snap;
    logic [PW-1:0]             wptr;
    logic [PW:0]               lcount;
    logic [PW-1:0]             lsel;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  logic              mem_wr_en;
  logic [PW-1:0]     mem_rd_addr;
  thd_pkg::log_rec_t mem_wr_data;
  thd_pkg::log_rec_t mem_rd_data;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  // pick-up with built-in hysteresis, evaluated on all three phases
  logic pick;
  always_comb begin
    logic [23:0] lhs;
    logic [23:0] rel_lim;
    lhs     = '0;
    rel_lim = 24'(state_ff.pickup) * 24'(`RESET_RATIO_PCT);
    pick    = 1'b0;
    for (int p = 0; p < 3; p++) begin
      lhs = 24'(phase_thd[p]) * 24'h64;
      if (state_ff.start || state_ff.alarm) begin
        if (lhs >= rel_lim) begin // RULE11
          pick = 1'b1;
        end
      end else if (24'(phase_thd[p]) > 24'(state_ff.pickup)) begin
        pick = 1'b1;
      end
    end
  end

  // newest record is selection 0; older ones count back around the ring
  always_comb begin
    int idx;
    idx = int'(state_ff.wptr) + LOG_DEPTH - 1 - int'(state_ff.lsel);
    if (idx >= LOG_DEPTH) begin
      idx = idx - LOG_DEPTH;
    end
    mem_rd_addr = PW'(idx);
  end

  always_comb begin
    logic              blk;
    logic              n_start;
    logic              n_alarm;
    logic              n_blk;
    thd_pkg::ev_vec_t  evs;
    thd_pkg::ev_vec_t  keep;
    logic [2:0]        ons;
    logic [2:0]        done;
    logic [2:0]        clr_cnt;
    logic [31:0]       m;
    logic [31:0]       w;
    nxt_state   = state_ff;
    blk         = 1'b0;
    n_start     = state_ff.start;
    n_alarm     = state_ff.alarm;
    n_blk       = state_ff.blocked;
    evs         = '0;
    keep        = '0;
    ons         = '0;
    done        = '0;
    clr_cnt     = '0;
    m           = lane_mask(avs_byteenable);
    w           = '0;
    mem_wr_en   = 1'b0;
    mem_wr_data = state_ff.snap;
    nxt_state.ev.valid = 1'b0;

    if (cycle_tick) begin
      blk     = block_in; // RULE13
      n_blk   = state_ff.en && blk && pick; // RULE12
      n_start = state_ff.en && !blk && pick; // RULE12
      if (n_start) begin
        n_alarm = state_ff.tmr >= state_ff.delay; // RULE1
        if (state_ff.tmr < state_ff.delay) begin
          nxt_state.tmr = state_ff.tmr + DELAY_W'(1);
        end
      end else begin
        n_alarm       = 1'b0; // RULE14
        nxt_state.tmr = '0; // RULE14
      end
      evs[`EVB_START_ON]  = n_start && !state_ff.start; // RULE3
      evs[`EVB_START_OFF] = !n_start && state_ff.start;
      evs[`EVB_ALARM_ON]  = n_alarm && !state_ff.alarm;
      evs[`EVB_ALARM_OFF] = !n_alarm && state_ff.alarm;
      evs[`EVB_BLK_ON]    = n_blk && !state_ff.blocked;
      evs[`EVB_BLK_OFF]   = !n_blk && state_ff.blocked;
      nxt_state.start   = n_start;
      nxt_state.alarm   = n_alarm;
      nxt_state.blocked = n_blk;
    end

    keep[`EVB_START_ON]  = state_ff.sel_start[`SEL_ON_BIT]; // RULE4
    keep[`EVB_START_OFF] = state_ff.sel_start[`SEL_OFF_BIT];
    keep[`EVB_ALARM_ON]  = state_ff.sel_alarm[`SEL_ON_BIT];
    keep[`EVB_ALARM_OFF] = state_ff.sel_alarm[`SEL_OFF_BIT];
    keep[`EVB_BLK_ON]    = state_ff.sel_blk[`SEL_ON_BIT];
    keep[`EVB_BLK_OFF]   = state_ff.sel_blk[`SEL_OFF_BIT];
    if ((evs & keep) != '0) begin
      nxt_state.ev.valid = 1'b1;
      nxt_state.ev.flags = evs & keep;
      nxt_state.ev.stamp = ts_ms; // RULE5
    end

    ons = {evs[`EVB_BLK_ON], evs[`EVB_ALARM_ON], evs[`EVB_START_ON]};
    if (ons != '0) begin
      nxt_state.snap.stamp = ts_ms; // RULE10
      nxt_state.snap.group = active_group;
      nxt_state.snap.thd   = phase_thd;
    end

    // one record per clock; ON events of one tick share the snapshot
    if (state_ff.pend != '0) begin
      mem_wr_en = 1'b1; // RULE9
      if (state_ff.pend[0]) begin
        done[0]          = 1'b1;
        mem_wr_data.kind = thd_pkg::EV_START;
      end else if (state_ff.pend[1]) begin
        done[1]          = 1'b1;
        mem_wr_data.kind = thd_pkg::EV_ALARM;
      end else begin
        done[2]          = 1'b1;
        mem_wr_data.kind = thd_pkg::EV_BLOCKED;
      end
      if (int'(state_ff.wptr) == LOG_DEPTH - 1) begin
        nxt_state.wptr = '0; // RULE8
      end else begin
        nxt_state.wptr = state_ff.wptr + PW'(1);
      end
      if (int'(state_ff.lcount) < LOG_DEPTH) begin
        nxt_state.lcount = state_ff.lcount + (PW+1)'(1);
      end
    end
    nxt_state.pend = (state_ff.pend & ~done) | ons;

    // bus: accept, answer one cycle later, commit at the master's edge
    nxt_state.waitreq = 1'b1;
    unique case (state_ff.bus)
      thd_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_state.bus = thd_pkg::BUS_ACK;
        end
      end
      thd_pkg::BUS_ACK: begin
        nxt_state.bus     = thd_pkg::BUS_DONE;
        nxt_state.waitreq = 1'b0;
        nxt_state.rdata   = '0;
        if (avs_read) begin
          case (avs_address)
            `REG_CTRL: begin
              nxt_state.rdata[`CTRL_EN_BIT]         = state_ff.en;
              nxt_state.rdata[`CTRL_SEL_START +: 2] = state_ff.sel_start;
              nxt_state.rdata[`CTRL_SEL_ALARM +: 2] = state_ff.sel_alarm;
              nxt_state.rdata[`CTRL_SEL_BLK +: 2]   = state_ff.sel_blk;
            end
            `REG_DELAY:     nxt_state.rdata[DELAY_W-1:0] = state_ff.delay;
            `REG_PICKUP:    nxt_state.rdata[13:0] = state_ff.pickup;
            `REG_STATUS: begin
              nxt_state.rdata[2:0]  = {state_ff.blocked, state_ff.alarm,
                                       state_ff.start};
              nxt_state.rdata[8 +: PW+1] = state_ff.lcount;
            end
            `REG_CNT_START: nxt_state.rdata = 32'(state_ff.cnt[0]);
            `REG_CNT_ALARM: nxt_state.rdata = 32'(state_ff.cnt[1]);
            `REG_CNT_BLK:   nxt_state.rdata = 32'(state_ff.cnt[2]);
            `REG_IRQ_STAT:  nxt_state.rdata[5:0] = state_ff.ist;
            `REG_IRQ_EN:    nxt_state.rdata[5:0] = state_ff.ien;
            `REG_LOG_SEL:   nxt_state.rdata[PW-1:0] = state_ff.lsel;
            `REG_LOG_W0:    nxt_state.rdata = mem_rd_data.stamp[31:0];
            `REG_LOG_W1: begin
              nxt_state.rdata[15:0]  = mem_rd_data.stamp[47:32];
              nxt_state.rdata[17:16] = mem_rd_data.kind;
              nxt_state.rdata[22:20] = mem_rd_data.group;
            end
            `REG_LOG_W2: nxt_state.rdata = {mem_rd_data.thd[1],
                                            mem_rd_data.thd[0]};
            `REG_LOG_W3: nxt_state.rdata[15:0] = mem_rd_data.thd[2];
            default:     nxt_state.rdata = '0;
          endcase
        end
      end
      thd_pkg::BUS_DONE: begin
        nxt_state.bus = thd_pkg::BUS_IDLE;
        if (avs_write) begin
          case (avs_address)
            `REG_CTRL: begin
              w = merge({24'h0, state_ff.sel_blk, state_ff.sel_alarm,
                         state_ff.sel_start, 1'b0, state_ff.en},
                        avs_writedata, m);
              nxt_state.en        = w[`CTRL_EN_BIT];
              nxt_state.sel_start = w[`CTRL_SEL_START +: 2];
              nxt_state.sel_alarm = w[`CTRL_SEL_ALARM +: 2];
              nxt_state.sel_blk   = w[`CTRL_SEL_BLK +: 2];
            end
            `REG_DELAY: begin
              w = merge(32'(state_ff.delay), avs_writedata, m);
              nxt_state.delay = w[DELAY_W-1:0]; // RULE2
            end
            `REG_PICKUP: begin
              w = merge(32'(state_ff.pickup), avs_writedata, m);
              nxt_state.pickup = w[13:0];
            end
            `REG_CNT_CLR: begin
              w       = avs_writedata & m;
              clr_cnt = w[2:0]; // RULE7
            end
            `REG_IRQ_CLR: begin
              w = avs_writedata & m;
              nxt_state.ist = state_ff.ist & ~w[5:0];
            end
            `REG_IRQ_EN: begin
              w = merge(32'(state_ff.ien), avs_writedata, m);
              nxt_state.ien = w[5:0];
            end
            `REG_LOG_SEL: begin
              w = merge(32'(state_ff.lsel), avs_writedata, m);
              // out-of-range picks clamp to the oldest slot
              if (w >= 32'(LOG_DEPTH)) begin
                nxt_state.lsel = PW'(LOG_DEPTH - 1);
              end else begin
                nxt_state.lsel = w[PW-1:0];
              end
            end
            default: begin
              w = '0;
            end
          endcase
        end
      end
      default: nxt_state.bus = thd_pkg::BUS_IDLE;
    endcase

    // a clear in the same cycle as a new activation still counts it
    for (int c = 0; c < 3; c++) begin
      if (clr_cnt[c]) begin
        nxt_state.cnt[c] = CNT_W'(ons[c]); // RULE7
      end else if (ons[c]) begin
        nxt_state.cnt[c] = state_ff.cnt[c] + CNT_W'(1); // RULE7
      end
    end
    nxt_state.ist = nxt_state.ist | evs;
    nxt_state.irq = (nxt_state.ist & nxt_state.ien) != '0;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff           <= '0;
      state_ff.bus       <= thd_pkg::BUS_IDLE;
      state_ff.waitreq   <= 1'b1;
      state_ff.en        <= 1'b1;
      state_ff.sel_start <= `SEL_RESET;
      state_ff.sel_alarm <= `SEL_RESET;
      state_ff.sel_blk   <= `SEL_RESET;
      state_ff.delay     <= DELAY_RST; // RULE2
      state_ff.pickup    <= `PICKUP_DEFAULT;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  log_mem #(
    .DEPTH (LOG_DEPTH),
    .AW    (PW)
  ) u_log_mem (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .wr_en    (mem_wr_en),
    .wr_addr  (state_ff.wptr),
    .wr_data  (mem_wr_data),
    .rd_addr  (mem_rd_addr),
    .rd_data  (mem_rd_data)
  );

  assign avs_readdata    = state_ff.rdata;
  assign avs_waitrequest = state_ff.waitreq;
  assign start_out       = state_ff.start; // RULE6
  assign alarm_out       = state_ff.alarm; // RULE6
  assign blocked_out     = state_ff.blocked; // RULE6
  assign ev_out          = state_ff.ev;
  assign irq             = state_ff.irq;

endmodule : thd_alarm_delay_event_logger

/* File: thd_logger_props.sv */
// concurrent checks on the ports of the distortion event logger
`timescale 1ns/1ps
module thd_logger_props #(
  parameter int DELAY_W   = 19,
  parameter int CNT_W     = 32,
  parameter int LOG_DEPTH = 12
) (
  input wire logic                    core_clk,
  input wire logic                    arst_n,
  input wire logic                    ce,
  input wire logic                    cycle_tick,
  input wire logic                    block_in,
  input wire thd_pkg::thd_val_t [2:0] phase_thd,
  input wire thd_pkg::stamp_t         ts_ms,
  input wire logic [2:0]              active_group,
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  input wire logic                    start_out,
  input wire logic                    alarm_out,
  input wire logic                    blocked_out,
  input wire thd_pkg::ev_msg_t        ev_out,
  input wire logic                    irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer_time: assert property (
    $rose(avs_read || avs_write) |-> ##1 s_answer)
    else $error("bus answer not two edges after request");
  chk_start_blk_excl: assert property (
    !(start_out && blocked_out))
    else $error("start and blocked high together");
  chk_alarm_with_start: assert property (
    alarm_out |-> start_out)
    else $error("alarm high without start");
  chk_live_on_tick: assert property (
    $changed({start_out, alarm_out, blocked_out})
    |-> $past(ce && cycle_tick) || $past(ce && cycle_tick, 2))
    else $error("live output changed away from a tick");
  chk_ev_one_pulse: assert property (
    ev_out.valid |=> !ev_out.valid)
    else $error("event word longer than one cycle");
  chk_start_on_ev: assert property (
    ev_out.valid && ev_out.flags[0] |-> start_out)
    else $error("start on event without start");
  chk_start_off_ev: assert property (
    ev_out.valid && ev_out.flags[1] |-> !start_out)
    else $error("start off event with start high");
  chk_alarm_on_ev: assert property (
    ev_out.valid && ev_out.flags[2] |-> alarm_out && start_out)
    else $error("alarm on event without alarm");
  chk_blk_on_ev: assert property (
    ev_out.valid && ev_out.flags[4] |-> blocked_out && !start_out)
    else $error("blocked on event without blocked");
  chk_ev_stamp_now: assert property (
    ev_out.valid |-> ev_out.stamp == ts_ms)
    else $error("event stamp differs from tick time");
endmodule : thd_logger_props

bind thd_alarm_delay_event_logger thd_logger_props #(
  .DELAY_W(DELAY_W), .CNT_W(CNT_W), .LOG_DEPTH(LOG_DEPTH)
) u_props (.core_clk, .arst_n, .ce, .cycle_tick, .block_in,
  .phase_thd, .ts_ms, .active_group, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .start_out, .alarm_out, .blocked_out, .ev_out,
  .irq);

/* File: thd_event_sink.sv */
// main event buffer and user logic beyond the event link
`timescale 1ns/1ps
module thd_event_sink (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire thd_pkg::ev_msg_t ev_out,
  input  wire logic             alarm_out,
  output thd_pkg::ev_vec_t      last_flags,
  output thd_pkg::stamp_t       last_stamp,
  output logic [7:0]            n_events,
  output logic [7:0]            n_alarms
);
  logic alarm_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_flags <= '0;
      last_stamp <= '0;
      n_events   <= 8'h00;
      n_alarms   <= 8'h00;
      alarm_q    <= 1'h0;
    end else begin
      // the buffer stores every word handed over, masking is upstream
      if (ev_out.valid) begin
        last_flags <= ev_out.flags;
        last_stamp <= ev_out.stamp;
        n_events   <= n_events + 8'h01;
      end
      alarm_q <= alarm_out;
      if (alarm_out && !alarm_q) begin
        n_alarms <= n_alarms + 8'h01;
      end
    end
  end
endmodule : thd_event_sink

/* File: thd_alarm_delay_event_logger_tb_top.sv */
// self-checking bench for the distortion alarm-delay and event logger
`timescale 1ns/1ps
`include "thd_params.svh"
module thd_alarm_delay_event_logger_tb_top;
  logic                    core_clk = 1'h0;
  logic                    arst_n = 1'h0;
  logic                    cycle_tick = 1'h0;
  logic                    block_in = 1'h0;
  thd_pkg::thd_val_t [2:0] phase_thd = '0;
  thd_pkg::stamp_t         ts_ms = 48'h0;
  logic [7:0]              avs_address = 8'h00;
  logic                    avs_read = 1'h0;
  logic                    avs_write = 1'h0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [31:0]             avs_readdata, rd;
  logic                    avs_waitrequest, irq;
  logic                    start_out, alarm_out, blocked_out;
  thd_pkg::ev_msg_t        ev_out;
  thd_pkg::ev_vec_t        last_flags;
  thd_pkg::stamp_t         last_stamp, t1, tn;
  logic [7:0]              n_events, n_alarms;
  int                      fails = 0;
  int                      checked = 0;
  always #5 core_clk = ~core_clk;
  thd_alarm_delay_event_logger DUT (.core_clk, .arst_n, .ce(1'h1),
    .cycle_tick, .block_in, .phase_thd, .ts_ms, .active_group(3'h5),
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .start_out,
    .alarm_out, .blocked_out, .ev_out, .irq);
  thd_event_sink sink (.core_clk, .arst_n, .ev_out, .alarm_out,
    .last_flags, .last_stamp, .n_events, .n_alarms);
  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus
  // ticks six clocks apart, each with a fresh time stamp
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge core_clk);
      ts_ms      <= ts_ms + 48'h1;
      cycle_tick <= 1'h1;
      @(posedge core_clk);
      cycle_tick <= 1'h0;
      repeat (4) @(posedge core_clk);
    end
  endtask : tick
  task automatic lv(input logic s, input logic a, input logic b);
    chk("live", {s, a, b}, {start_out, alarm_out, blocked_out});
  endtask : lv
  task automatic ev(input logic [5:0] f);
    chk("flags", f, last_flags);
    chk("stamp", ts_ms, last_stamp);
  endtask : ev
  task automatic t_reset;
    bus(1'h0, `REG_CTRL, 32'h0);
    chk("ctrl", 32'h000000fd, rd);
    bus(1'h0, `REG_DELAY, 32'h0);
    chk("delay", 32'h000007d0, rd);
    bus(1'h0, `REG_PICKUP, 32'h0);
    chk("pickup", 32'h000003e8, rd);
    bus(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_reset
  task automatic t_delay;
    bus(1'h1, `REG_DELAY, 32'h3);
    phase_thd[1] <= 16'h03e9;
    tick(1);
    lv(1'h1, 1'h0, 1'h0);
    ev(6'h01);
    tick(2);
    lv(1'h1, 1'h0, 1'h0);
    tick(1);
    lv(1'h1, 1'h1, 1'h0);
    ev(6'h04);
    phase_thd[1] <= 16'h03ca;
    tick(1);
    lv(1'h1, 1'h1, 1'h0);
    phase_thd[1] <= 16'h03c9;
    tick(1);
    lv(1'h0, 1'h0, 1'h0);
    ev(6'h0a);
    chk("user alarms", 8'h01, n_alarms);
    phase_thd[1] <= 16'h03e9;
    tick(3);
    phase_thd[1] <= 16'h0000;
    tick(1);
    phase_thd[1] <= 16'h03e9;
    tick(3);
    lv(1'h1, 1'h0, 1'h0);
    tick(1);
    lv(1'h1, 1'h1, 1'h0);
    phase_thd[1] <= 16'h0000;
    tick(1);
  endtask : t_delay
  task automatic t_block;
    phase_thd[1] <= 16'h03e9;
    block_in <= 1'h1;
    tick(1);
    lv(1'h0, 1'h0, 1'h1);
    ev(6'h10);
    block_in <= 1'h0;
    tick(1);
    ev(6'h21);
    block_in <= 1'h1;
    tick(1);
    lv(1'h0, 1'h0, 1'h1);
    ev(6'h12);
    block_in <= 1'h0;
    phase_thd[1] <= 16'h0000;
    tick(1);
    ev(6'h20);
  endtask : t_block
  task automatic t_mask;
    logic [7:0] n0;
    for (int s = 1; s < 3; s++) begin
      bus(1'h1, `REG_CTRL, 32'h000000f1 | (32'(s) << 2));
      n0 = n_events;
      phase_thd[1] <= 16'h03e9;
      tick(1);
      chk("on kept", n0 + 8'(s == 1), n_events);
      phase_thd[1] <= 16'h0000;
      tick(1);
      chk("off kept", n0 + 8'h01, n_events);
      chk("kept flags", (s == 1) ? 6'h01 : 6'h02, last_flags);
    end
    phase_thd[1] <= 16'h03e9;
    tick(1);
    bus(1'h1, `REG_CTRL, 32'h000000fc);
    tick(1);
    lv(1'h0, 1'h0, 1'h0);
    ev(6'h02);
    bus(1'h1, `REG_CTRL, 32'h000000fd);
  endtask : t_mask
  task automatic t_count;
    bus(1'h1, `REG_CNT_CLR, 32'h7);
    for (int i = 0; i < 3; i++) begin
      bus(1'h0, `REG_CNT_START + 8'(4 * i), 32'h0);
      chk("cleared", 32'h0, rd);
    end
    bus(1'h1, `REG_DELAY, 32'h0);
    for (int j = 0; j < 3; j++) begin
      block_in <= (j == 2);
      phase_thd[1] <= 16'h03e9;
      tick(1);
      if (j < 2) ev(6'h05);
      block_in <= 1'h0;
      phase_thd[1] <= 16'h0000;
      tick(1);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1'h0, `REG_CNT_START + 8'(4 * i), 32'h0);
      chk("count", (i == 2) ? 32'h1 : 32'h2, rd);
    end
  endtask : t_count
  task automatic t_log;
    bus(1'h1, `REG_DELAY, 32'h000007d0);
    for (int i = 0; i < 13; i++) begin
      phase_thd[1] <= 16'h03e9;
      tick(1);
      if (i == 1) t1 = ts_ms;
      tn = ts_ms;
      phase_thd[1] <= 16'h0000;
      tick(1);
    end
    bus(1'h0, `REG_STATUS, 32'h0);
    chk("stored", 32'h00000c00, rd);
    bus(1'h1, `REG_LOG_SEL, 32'h0);
    bus(1'h0, `REG_LOG_W0, 32'h0);
    chk("newest time", tn[31:0], rd);
    bus(1'h0, `REG_LOG_W1, 32'h0);
    chk("newest kind", {16'h0050, tn[47:32]}, rd);
    bus(1'h0, `REG_LOG_W2, 32'h0);
    chk("newest thd", 32'h03e90000, rd);
    bus(1'h0, `REG_LOG_W3, 32'h0);
    chk("newest thd2", 32'h0, rd);
    bus(1'h1, `REG_LOG_SEL, 32'h0000000b);
    bus(1'h0, `REG_LOG_W0, 32'h0);
    chk("oldest time", t1[31:0], rd);
  endtask : t_log
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    chk("irq", e, irq);
  endtask : irq_is
  task automatic t_irq;
    bus(1'h1, `REG_IRQ_CLR, 32'h3f);
    bus(1'h1, `REG_IRQ_EN, 32'h1);
    irq_is(1'h0);
    phase_thd[1] <= 16'h03e9;
    tick(1);
    irq_is(1'h1);
    bus(1'h0, `REG_IRQ_STAT, 32'h0);
    chk("irq stat", 32'h1, rd);
    bus(1'h1, `REG_IRQ_EN, 32'h0);
    irq_is(1'h0);
    bus(1'h1, `REG_IRQ_EN, 32'h1);
    irq_is(1'h1);
    bus(1'h1, `REG_IRQ_CLR, 32'h1);
    irq_is(1'h0);
    phase_thd[1] <= 16'h0000;
    tick(1);
    irq_is(1'h0);
    bus(1'h0, `REG_IRQ_STAT, 32'h0);
    chk("irq stat off", 32'h2, rd);
  endtask : t_irq
  initial begin
    #200us;
    fails++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'h1;
    t_reset();
    t_delay();
    t_block();
    t_mask();
    t_count();
    t_log();
    t_irq();
    conclude();
  end
endmodule : thd_alarm_delay_event_logger_tb_top
